// ---- verilog/fxr_ext_read.v ----
// Extended read register with serial command front end
// What this block does
// - Default dummy: 8 single/dual/quad out, 6, 4
// - Unique id and row reads use fast dummy
// - Dual I/O double-rate read rejected in QPI
// - Eight bits: strength, reserved, four flags
// - Set commands never alter the status flags
// - 85h writes non-volatile, 83h writes volatile
// - Strength codes; 000 and 100 reserved
// - Bit 0 mirrors write-in-progress, one clock later at ext_status_o
// - Protected target sets protection violation flag
// - Program commands set program error on failure
// - Bad lock bits program sets both flags
// - Wrong unlock password sets both flags
// - Non-volatile update failures set matching flag
// - Locked status write sets protection and erase
// - Erase commands set erase error on failure
// - Chip erase flags only block protection
// - Clearing one-time bits ignored, no error
// - Read-only or frozen bits dropped silently
// - Flags sticky until clear command or reset
// - Commands still run with flags set
`timescale 1ns/1ps
`include "fxr_defs.vh"
module fxr_ext_read (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_b_i,
    // Serial link pins
    input wire sck_i,
    input wire cs_b_i,
    input wire [3:0] io_i,
    output reg [3:0] io_o,
    output reg [3:0] io_oe_o,
    // Device state, same clock domain
    input wire qpi_mode_i,
    input wire wip_i,
    input wire soft_rst_i,
    // Finished operation description
    input wire [3:0] op_kind_i,
    input wire prog_fail_i,
    input wire erase_fail_i,
    input wire area_protected_i,
    input wire area_suspended_i,
    input wire row_locked_i,
    input wire bp_protected_i,
    input wire mode_locked_i,
    input wire [1:0] lock_bits_data_i,
    input wire otp_clear_only_i,
    input wire pwd_mismatch_i,
    input wire status_write_disable_bit_i,
    // Write protect pin
    input wire wp_b_i,
    // Register and read control outputs
    output reg [7:0] ext_status_o,
    output reg [2:0] drive_strength_o,
    output reg [2:0] nv_drive_strength_o,
    output reg nv_update_req_o,
    output reg read_start_o,
    output reg [3:0] dummy_cycles_o,
    output reg cmd_reject_o
);
    // Pin synchronisers
    reg sck_s1_reg, sck_s2_reg, sck_s3_reg;
    reg cs_s1_reg, cs_s2_reg, cs_s3_reg;
    reg [3:0] io_s1_reg, io_s2_reg;
    reg wp_s1_reg, wp_s2_reg;
    // Serial engine
    reg [4:0] cnt_reg, cnt_next;
    reg [15:0] shift_reg, shift_next;
    reg [7:0] tx_reg;
    reg tx_on_reg;
    reg [2:0] tx_pos_reg;
    // Register state
    reg [2:0] vol_ods_reg, nv_ods_reg, nv_pend_reg;
    reg prot_reg, perr_reg, eerr_reg;
    reg nv_busy_reg, loaded_reg, wip_d_reg;

    wire sck_rise = sck_s2_reg & ~sck_s3_reg;
    wire sck_fall = ~sck_s2_reg & sck_s3_reg;
    wire cs_active = ~cs_s2_reg;
    wire cs_end = cs_s2_reg & ~cs_s3_reg;
    // Results are taken in the cycle busy drops
    wire op_done = wip_d_reg & ~wip_i;
    wire [7:0] opcode = shift_reg[7:0];
    wire [7:0] wr_data = shift_reg[7:0];
    wire [7:0] wr_opcode = shift_reg[15:8];
    wire set_prot, set_perr, set_eerr;
    wire [7:0] ext_now;

    // Bit 0 taken straight from the status bit
    assign ext_now = {vol_ods_reg, 1'b1, eerr_reg, perr_reg,
                      prot_reg, wip_i};

    // Write protect pin reaches the classifier synchronised
    fxr_err_class u_class (
        .op_kind_i(op_kind_i),
        .prog_fail_i(prog_fail_i),
        .erase_fail_i(erase_fail_i),
        .area_protected_i(area_protected_i),
        .area_suspended_i(area_suspended_i),
        .row_locked_i(row_locked_i),
        .bp_protected_i(bp_protected_i),
        .mode_locked_i(mode_locked_i),
        .lock_bits_data_i(lock_bits_data_i),
        .otp_clear_only_i(otp_clear_only_i),
        .pwd_mismatch_i(pwd_mismatch_i),
        .status_write_disable_bit_i(status_write_disable_bit_i),
        .wp_b_i(wp_s2_reg),
        .set_prot_o(set_prot),
        .set_perr_o(set_perr),
        .set_eerr_o(set_eerr)
    );

    // Dummy count for a read opcode: {valid, count}
    function [4:0] dummy_for;
        input [7:0] op;
        input qpi;
        begin
            case (op)
                `FXR_OP_FRD, `FXR_OP_FRD4, `FXR_OP_FRDTR, `FXR_OP_FRDTR4,
                `FXR_OP_RD_UID, `FXR_OP_IR_RD:
                    dummy_for = qpi ? {1'b1, `FXR_DUMMY_QPI_FAST}
                                    : {1'b1, `FXR_DUMMY_SPI_FAST};
                `FXR_OP_DOR, `FXR_OP_DOR4, `FXR_OP_QOR, `FXR_OP_QOR4:
                    dummy_for = {1'b1, `FXR_DUMMY_SPI_FAST};
                `FXR_OP_DIO, `FXR_OP_DIO4, `FXR_OP_DIODTR, `FXR_OP_DIODTR4:
                    dummy_for = {1'b1, `FXR_DUMMY_DUAL_IO};
                `FXR_OP_QIO, `FXR_OP_QIO4, `FXR_OP_QIODTR, `FXR_OP_QIODTR4:
                    dummy_for = {1'b1, `FXR_DUMMY_QUAD_IO};
                default:
                    dummy_for = 5'h00;
            endcase
        end
    endfunction

    // Decode on the edge that completes the eighth bit
    wire [4:0] dummy_sel = dummy_for(shift_next[7:0], qpi_mode_i);
    wire is_dio_dtr = (shift_next[7:0] == `FXR_OP_DIODTR) ||
                      (shift_next[7:0] == `FXR_OP_DIODTR4);
    wire op_complete = sck_rise && cs_active && cnt_reg < 5'h08 &&
                       cnt_next == 5'h08;
    // Reserved strength codes leave the old value
    wire ods_ok = wr_data[7:5] != `FXR_ODS_RSV_A &&
                  wr_data[7:5] != `FXR_ODS_RSV_B;
    // The count still stands in the cycle select rises
    wire wr_end = cs_end && cnt_reg == 5'h10;
    wire clr_end = cs_end && cnt_reg == 5'h08 &&
                   opcode == `FXR_OP_CLR_ERR;
    // Fresh snapshot at each byte so polling sees busy end
    wire [7:0] tx_src = (tx_pos_reg == 3'h0) ? ext_now : tx_reg;

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_s3_reg <= 1'b0;
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            io_s1_reg <= 4'h0;
            io_s2_reg <= 4'h0;
            wp_s1_reg <= 1'b1;
            wp_s2_reg <= 1'b1;
        end else begin
            sck_s1_reg <= sck_i;
            sck_s2_reg <= sck_s1_reg;
            sck_s3_reg <= sck_s2_reg;
            cs_s1_reg <= cs_b_i;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            io_s1_reg <= io_i;
            io_s2_reg <= io_s1_reg;
            wp_s1_reg <= wp_b_i;
            wp_s2_reg <= wp_s1_reg;
        end
    end

    // Shift in one bit per edge in SPI, a nibble in QPI
    always @* begin
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        // Count saturates so an overlong frame is never a write
        if (sck_rise && cs_active) begin
            if (qpi_mode_i) begin
                shift_next = {shift_reg[11:0], io_s2_reg};
                cnt_next = (cnt_reg > 5'h1B) ? 5'h1F : cnt_reg + 5'h04;
            end else begin
                shift_next = {shift_reg[14:0], io_s2_reg[0]};
                cnt_next = (cnt_reg == 5'h1F) ? 5'h1F : cnt_reg + 5'h01;
            end
        end
    end

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_reg <= 5'h00;
            shift_reg <= 16'h0000;
            tx_reg <= 8'h00;
            tx_on_reg <= 1'b0;
            tx_pos_reg <= 3'h0;
            io_o <= 4'h0;
            io_oe_o <= 4'h0;
            read_start_o <= 1'b0;
            dummy_cycles_o <= 4'h0;
            cmd_reject_o <= 1'b0;
        end else begin
            read_start_o <= 1'b0;
            cmd_reject_o <= 1'b0;
            // Frame ends: drop the count and release the lines
            if (!cs_active) begin
                cnt_reg <= 5'h00;
                tx_on_reg <= 1'b0;
                tx_pos_reg <= 3'h0;
                io_oe_o <= 4'h0;
            end else begin
                cnt_reg <= cnt_next;
                shift_reg <= shift_next;
            end
            if (op_complete) begin
                if (shift_next[7:0] == `FXR_OP_RD_EXT) begin
                    tx_reg <= ext_now;
                    tx_on_reg <= 1'b1;
                    tx_pos_reg <= 3'h0;
                end else if (qpi_mode_i && is_dio_dtr) begin
                    cmd_reject_o <= 1'b1;
                end else if (dummy_sel[4]) begin
                    read_start_o <= 1'b1;
                    dummy_cycles_o <= dummy_sel[3:0];
                end
            end
            // Register read: wraps so polling continues
            if (sck_fall && tx_on_reg) begin
                if (qpi_mode_i) begin
                    io_o <= tx_src[7:4];
                    io_oe_o <= 4'hF;
                    tx_reg <= {tx_src[3:0], tx_src[7:4]};
                    tx_pos_reg <= tx_pos_reg + 3'h4;
                end else begin
                    io_o <= {2'h0, tx_src[7], 1'b0};
                    io_oe_o <= 4'h2;
                    tx_reg <= {tx_src[6:0], tx_src[7]};
                    tx_pos_reg <= tx_pos_reg + 3'h1;
                end
            end
        end
    end

    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vol_ods_reg <= `FXR_ODS_RESET;
            nv_ods_reg <= `FXR_ODS_RESET;
            nv_pend_reg <= `FXR_ODS_RESET;
            nv_busy_reg <= 1'b0;
            nv_update_req_o <= 1'b0;
            loaded_reg <= 1'b0;
            wip_d_reg <= 1'b0;
            prot_reg <= 1'b0;
            perr_reg <= 1'b0;
            eerr_reg <= 1'b0;
            ext_status_o <= `FXR_EXT_RESET;
            drive_strength_o <= `FXR_ODS_RESET;
            nv_drive_strength_o <= `FXR_ODS_RESET;
        end else begin
            nv_update_req_o <= 1'b0;
            wip_d_reg <= wip_i;
            loaded_reg <= 1'b1;
            if (!loaded_reg)
                vol_ods_reg <= nv_ods_reg;
            // Only the strength field is written; rest dropped
            if (wr_end && ods_ok && wr_opcode == `FXR_OP_SET_V) begin
                vol_ods_reg <= wr_data[7:5];
            end
            if (wr_end && ods_ok && wr_opcode == `FXR_OP_SET_NV) begin
                nv_pend_reg <= wr_data[7:5];
                nv_busy_reg <= 1'b1;
                nv_update_req_o <= 1'b1;
            end
            // Commit the stored copy only after a clean update
            if (op_done && nv_busy_reg && op_kind_i == `FXR_K_NV_REG) begin
                nv_busy_reg <= 1'b0;
                if (!set_perr && !set_eerr)
                    nv_ods_reg <= nv_pend_reg;
            end
            // Set beats clear; flags never block commands
            if (op_done && set_prot)
                prot_reg <= 1'b1;
            else if (clr_end || soft_rst_i)
                prot_reg <= 1'b0;
            if (op_done && set_perr)
                perr_reg <= 1'b1;
            else if (clr_end || soft_rst_i)
                perr_reg <= 1'b0;
            if (op_done && set_eerr)
                eerr_reg <= 1'b1;
            else if (clr_end || soft_rst_i)
                eerr_reg <= 1'b0;
            // Registered copy of the live register
            ext_status_o <= ext_now;
            drive_strength_o <= vol_ods_reg;
            nv_drive_strength_o <= nv_ods_reg;
        end
    end
endmodule

// ---- verilog/fxr_defs.vh ----
// Opcodes, field positions, reset values and operation codes
`ifndef FXR_DEFS_VH
`define FXR_DEFS_VH

// Register commands
`define FXR_OP_SET_NV 8'h85
`define FXR_OP_SET_V 8'h83
`define FXR_OP_RD_EXT 8'h81
`define FXR_OP_CLR_ERR 8'h82
`define FXR_OP_RD_UID 8'h4B
`define FXR_OP_IR_RD 8'h68

// Fast read opcodes
`define FXR_OP_FRD 8'h0B
`define FXR_OP_FRD4 8'h0C
`define FXR_OP_FRDTR 8'h0D
`define FXR_OP_FRDTR4 8'h0E
`define FXR_OP_DOR 8'h3B
`define FXR_OP_DOR4 8'h3C
`define FXR_OP_DIO 8'hBB
`define FXR_OP_DIO4 8'hBC
`define FXR_OP_DIODTR 8'hBD
`define FXR_OP_DIODTR4 8'hBE
`define FXR_OP_QOR 8'h6B
`define FXR_OP_QOR4 8'h6C
`define FXR_OP_QIO 8'hEB
`define FXR_OP_QIO4 8'hEC
`define FXR_OP_QIODTR 8'hED
`define FXR_OP_QIODTR4 8'hEE

// Default dummy cycle counts
`define FXR_DUMMY_SPI_FAST 4'h8
`define FXR_DUMMY_QPI_FAST 4'h6
`define FXR_DUMMY_DUAL_IO 4'h4
`define FXR_DUMMY_QUAD_IO 4'h6

// Extended read register layout
`define FXR_ODS_MSB 7
`define FXR_ODS_LSB 5
`define FXR_RSV_BIT 4
`define FXR_EERR_BIT 3
`define FXR_PERR_BIT 2
`define FXR_PROT_BIT 1
`define FXR_WIP_BIT 0
`define FXR_EXT_RESET 8'hF0
`define FXR_ODS_RESET 3'h7
`define FXR_ODS_RSV_A 3'h0
`define FXR_ODS_RSV_B 3'h4

// Internal operation kinds
`define FXR_K_NONE 4'h0
`define FXR_K_PAGE_PROG 4'h1
`define FXR_K_PPB_PROG 4'h2
`define FXR_K_PWD_PROG 4'h3
`define FXR_K_IR_PROG 4'h4
`define FXR_K_FUNC_WR 4'h5
`define FXR_K_PROT_CFG 4'h6
`define FXR_K_PWD_UNLOCK 4'h7
`define FXR_K_NV_REG 4'h8
`define FXR_K_STATUS_WR 4'h9
`define FXR_K_SECT_ERASE 4'hA
`define FXR_K_CHIP_ERASE 4'hB
`define FXR_K_IR_ERASE 4'hC
`define FXR_K_PPB_ERASE 4'hD

`endif

// ---- verilog/fxr_err_class.v ----
// Maps a finished internal operation to the error flags it raises
`timescale 1ns/1ps
`include "fxr_defs.vh"
module fxr_err_class (
    // Operation description
    input wire [3:0] op_kind_i,
    input wire prog_fail_i,
    input wire erase_fail_i,
    input wire area_protected_i,
    input wire area_suspended_i,
    input wire row_locked_i,
    input wire bp_protected_i,
    input wire mode_locked_i,
    input wire [1:0] lock_bits_data_i,
    input wire otp_clear_only_i,
    input wire pwd_mismatch_i,
    input wire status_write_disable_bit_i,
    input wire wp_b_i,
    // Flags to set
    output reg set_prot_o,
    output reg set_perr_o,
    output reg set_eerr_o
);
    reg lock_err;
    reg hit;

    always @* begin
        set_prot_o = 1'b0;
        set_perr_o = 1'b0;
        set_eerr_o = 1'b0;
        lock_err = 1'b0;
        hit = 1'b0;
        case (op_kind_i)
            `FXR_K_PAGE_PROG, `FXR_K_PPB_PROG, `FXR_K_PWD_PROG: begin
                hit = area_protected_i | area_suspended_i;
                set_perr_o = prog_fail_i | hit;
                set_prot_o = hit;
            end
            `FXR_K_IR_PROG: begin
                set_perr_o = prog_fail_i | row_locked_i;
                set_prot_o = row_locked_i;
            end
            `FXR_K_FUNC_WR: begin
                set_perr_o = prog_fail_i;
            end
            `FXR_K_PROT_CFG: begin
                lock_err = mode_locked_i | (lock_bits_data_i == 2'h0);
                // Only clearing a one-time bit: quietly dropped
                if (!otp_clear_only_i) begin
                    set_perr_o = prog_fail_i | lock_err;
                    set_prot_o = lock_err;
                end
            end
            `FXR_K_PWD_UNLOCK: begin
                set_perr_o = prog_fail_i | pwd_mismatch_i;
                set_prot_o = pwd_mismatch_i;
            end
            `FXR_K_NV_REG: begin
                set_perr_o = prog_fail_i;
                set_eerr_o = erase_fail_i;
            end
            `FXR_K_STATUS_WR: begin
                if (status_write_disable_bit_i && !wp_b_i) begin
                    set_prot_o = 1'b1;
                    set_eerr_o = 1'b1;
                end else begin
                    set_perr_o = prog_fail_i;
                    set_eerr_o = erase_fail_i;
                end
            end
            `FXR_K_SECT_ERASE, `FXR_K_IR_ERASE, `FXR_K_PPB_ERASE: begin
                hit = area_protected_i | row_locked_i;
                set_eerr_o = erase_fail_i | hit;
                set_prot_o = hit;
            end
            `FXR_K_CHIP_ERASE: begin
                // Sector lock bits alone do not count here
                set_eerr_o = erase_fail_i | bp_protected_i;
                set_prot_o = bp_protected_i;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end
endmodule

// ---- tb/fxr_ext_read_properties.sv ----
// Port-level checks for the extended read register block
`timescale 1ns/1ps
`include "fxr_defs.vh"
module fxr_ext_read_chk (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_b_i,
    // Watched inputs
    input wire cs_b_i,
    input wire qpi_mode_i,
    input wire wip_i,
    input wire soft_rst_i,
    input wire [3:0] op_kind_i,
    input wire prog_fail_i,
    input wire erase_fail_i,
    input wire bp_protected_i,
    input wire pwd_mismatch_i,
    // Watched outputs
    input wire [7:0] ext_status_o,
    input wire [2:0] drive_strength_o,
    input wire [2:0] nv_drive_strength_o,
    input wire read_start_o,
    input wire cmd_reject_o
);
    reg [3:0] clr_age_reg;
    reg cs_d_reg;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // Cycles since the last soft reset or frame end, saturating
    always @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clr_age_reg <= 4'hF;
            cs_d_reg <= 1'b1;
        end else begin
            cs_d_reg <= cs_b_i;
            if (soft_rst_i || (cs_b_i && !cs_d_reg))
                clr_age_reg <= 4'h0;
            else if (clr_age_reg != 4'hF)
                clr_age_reg <= clr_age_reg + 4'h1;
        end
    end
    property p_wip;
        (wip_i[*3] or (!wip_i)[*3]) |-> ext_status_o[0] == wip_i;
    endproperty
    a_wip: assert property (p_wip) else $error("wip mirror");
    property p_rsv;
        ext_status_o[4];
    endproperty
    a_rsv: assert property (p_rsv) else $error("bit 4 not 1");
    property p_ods;
        drive_strength_o != 3'h0 && drive_strength_o != 3'h4 &&
            nv_drive_strength_o != 3'h0 && nv_drive_strength_o != 3'h4;
    endproperty
    a_ods: assert property (p_ods) else $error("reserved code");
    property p_sticky;
        |($past(ext_status_o[3:1]) & ~ext_status_o[3:1]) |->
            clr_age_reg < 4'h8;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_perr;
        $fell(wip_i) && op_kind_i == `FXR_K_PAGE_PROG && prog_fail_i |->
            ##[2:3] ext_status_o[2];
    endproperty
    a_perr: assert property (p_perr) else $error("perr missing");
    property p_eerr;
        $fell(wip_i) && op_kind_i == `FXR_K_SECT_ERASE && erase_fail_i |->
            ##[2:3] ext_status_o[3];
    endproperty
    a_eerr: assert property (p_eerr) else $error("eerr missing");
    property p_chip;
        $fell(wip_i) && op_kind_i == `FXR_K_CHIP_ERASE && bp_protected_i
            |-> ##[2:3] ext_status_o[3] && ext_status_o[1];
    endproperty
    a_chip: assert property (p_chip) else $error("chip flags");
    property p_unlock;
        $fell(wip_i) && op_kind_i == `FXR_K_PWD_UNLOCK && pwd_mismatch_i
            |-> ##[2:3] ext_status_o[2:1] == 2'b11;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock");
    property p_reject;
        cmd_reject_o |-> qpi_mode_i ##1 !cmd_reject_o;
    endproperty
    a_reject: assert property (p_reject) else $error("reject");
    property p_late;
        $rose(ext_status_o[2]) |-> $past(wip_i, 3) || $past(wip_i, 4);
    endproperty
    a_late: assert property (p_late) else $error("early flag");
    c_reject: cover property (cmd_reject_o);
    c_read: cover property (read_start_o);
    c_clear: cover property ($fell(ext_status_o[2]));
endmodule

bind fxr_ext_read fxr_ext_read_chk fxr_ext_read_chk_i (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i),
    .qpi_mode_i(qpi_mode_i), .wip_i(wip_i), .soft_rst_i(soft_rst_i),
    .op_kind_i(op_kind_i), .prog_fail_i(prog_fail_i),
    .erase_fail_i(erase_fail_i), .bp_protected_i(bp_protected_i),
    .pwd_mismatch_i(pwd_mismatch_i), .ext_status_o(ext_status_o),
    .drive_strength_o(drive_strength_o),
    .nv_drive_strength_o(nv_drive_strength_o),
    .read_start_o(read_start_o), .cmd_reject_o(cmd_reject_o)
);

// ---- tb/fxr_host_model.sv ----
// Behavioural host controller driving the serial link pins
`timescale 1ns/1ps
module fxr_host_model (
    // Clock
    input wire clk_sys_i,
    // Link pins toward the device
    output reg sck_o,
    output reg cs_b_o,
    output reg [3:0] io_o,
    // Resolved data lines
    input wire [3:0] line_i
);
    initial begin
        sck_o = 1'b0;
        cs_b_o = 1'b1;
        io_o = 4'h5;
    end
    // Link clock half period is four system cycles; idle clock stays low
    task automatic xfer(input [15:0] tx, input integer nb, input qpi,
                        output [7:0] rx);
        integer k;
        reg [15:0] sh;
        begin
            sh = tx;
            rx = 8'h00;
            @(posedge clk_sys_i);
            cs_b_o <= 1'b0;
            for (k = 0; k < nb; k = k + (qpi ? 4 : 1)) begin
                io_o <= qpi ? sh[15:12] : {~io_o[3:1], sh[15]};
                sh = qpi ? sh << 4 : sh << 1;
                repeat (4) @(posedge clk_sys_i);
                sck_o <= 1'b1;
                rx = qpi ? {rx[3:0], line_i} : {rx[6:0], line_i[1]};
                repeat (4) @(posedge clk_sys_i);
                sck_o <= 1'b0;
            end
            repeat (4) @(posedge clk_sys_i);
            cs_b_o <= 1'b1;
            // Released lines must not keep showing the last value
            io_o <= ~io_o;
            repeat (10) @(posedge clk_sys_i);
        end
    endtask
endmodule

// ---- tb/fxr_ext_read_tb.sv ----
// Self-checking bench for the extended read register block
`timescale 1ns/1ps
`include "fxr_defs.vh"
module fxr_ext_read_tb;
    localparam [103:0] OPS = {8'hEB, 8'h4B, 8'h0B, 8'h68, 8'h4B, 8'hED,
        8'hEB, 8'h6B, 8'hBD, 8'hBB, 8'h3B, 8'h0D, 8'h0B};
    reg clk_sys_i = 1'b0;
    reg rst_b_i = 1'b0;
    reg qpi_mode_i = 1'b0;
    reg wip_i = 1'b0;
    reg soft_rst_i = 1'b0;
    reg [3:0] op_kind_i = 4'h0;
    reg [12:0] cond = 13'h0031;
    wire sck, cs_b, nv_req, rd_start, reject;
    wire [3:0] host_io, dev_io, dev_oe, line, dummy;
    wire [7:0] ext_status_o;
    wire [2:0] ds_o, nv_ds_o;
    integer fail_count = 0;
    integer checked = 0;
    integer cycles = 0;
    integer seed = 32'h82e7;
    integer i;
    reg [7:0] rx;
    reg [2:0] code;
    reg [2:0] ods = 3'h7;
    reg rej_seen = 1'b0;
    reg rd_seen = 1'b0;
    reg nv_seen = 1'b0;

    always #50 clk_sys_i = ~clk_sys_i;
    assign line = (dev_oe & dev_io) | (~dev_oe & host_io);

    fxr_ext_read fxr_ext_read_i (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sck_i(sck),
        .cs_b_i(cs_b), .io_i(line), .io_o(dev_io), .io_oe_o(dev_oe),
        .qpi_mode_i(qpi_mode_i), .wip_i(wip_i), .soft_rst_i(soft_rst_i),
        .op_kind_i(op_kind_i), .prog_fail_i(cond[12]),
        .erase_fail_i(cond[11]), .area_protected_i(cond[10]),
        .area_suspended_i(cond[9]), .row_locked_i(cond[8]),
        .bp_protected_i(cond[7]), .mode_locked_i(cond[6]),
        .lock_bits_data_i(cond[5:4]), .otp_clear_only_i(cond[3]),
        .pwd_mismatch_i(cond[2]), .status_write_disable_bit_i(cond[1]),
        .wp_b_i(cond[0]), .ext_status_o(ext_status_o),
        .drive_strength_o(ds_o), .nv_drive_strength_o(nv_ds_o),
        .nv_update_req_o(nv_req), .read_start_o(rd_start),
        .dummy_cycles_o(dummy), .cmd_reject_o(reject)
    );
    fxr_host_model fxr_host_model_i (.clk_sys_i(clk_sys_i), .sck_o(sck),
        .cs_b_o(cs_b), .io_o(host_io), .line_i(line));

    task check(input [15:0] seen, input [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checked, fail_count);
            if (fail_count == 0 && checked > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    function [3:0] exp_dummy(input [7:0] op, input q);
        begin
            case (op)
                8'hBB, 8'hBC, 8'hBD, 8'hBE: exp_dummy = 4'h4;
                8'h3B, 8'h3C, 8'h6B, 8'h6C: exp_dummy = 4'h8;
                8'hEB, 8'hEC, 8'hED, 8'hEE: exp_dummy = 4'h6;
                default: exp_dummy = q ? 4'h6 : 4'h8;
            endcase
        end
    endfunction
    task xfer(input [15:0] tx, input integer nb);
        begin
            fxr_host_model_i.xfer(tx, nb, qpi_mode_i, rx);
        end
    endtask
    // One finished internal operation, then flags checked and held
    task op_run(input [3:0] k, input [12:0] c, input [2:0] f);
        begin
            wip_i <= 1'b1;
            op_kind_i <= k;
            cond <= c;
            repeat (4) @(posedge clk_sys_i);
            check(ext_status_o[0], 1'b1);
            wip_i <= 1'b0;
            repeat (5) @(posedge clk_sys_i);
            check(ext_status_o[3:1], f);
            op_kind_i <= 4'h0;
            cond <= 13'h0031;
            repeat (20) @(posedge clk_sys_i);
            check(ext_status_o[3:1], f);
        end
    endtask
    task op_chk(input [3:0] k, input [12:0] c, input [2:0] f);
        begin
            op_run(k, c, f);
            if (1'($random(seed)))
                xfer({`FXR_OP_CLR_ERR, 8'h00}, 8);
            else begin
                soft_rst_i <= 1'b1;
                @(posedge clk_sys_i);
                soft_rst_i <= 1'b0;
            end
            repeat (4) @(posedge clk_sys_i);
            check(ext_status_o[3:1], 3'h0);
        end
    endtask

    always @(posedge clk_sys_i) begin
        cycles = cycles + 1;
        if (nv_req)
            nv_seen = 1'b1;
        if (reject)
            rej_seen = 1'b1;
        if (rd_start)
            rd_seen = 1'b1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            test_done;
        end
    end

    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        check(ext_status_o, 8'hF0);
        for (i = 0; i < 13; i = i + 1) begin
            qpi_mode_i <= (i > 9);
            @(posedge clk_sys_i);
            rd_seen = 1'b0;
            xfer({OPS[8 * i +: 8], 8'h00}, 8);
            check(dummy, exp_dummy(OPS[8 * i +: 8], qpi_mode_i));
            check(rej_seen, 1'b0);
            check(rd_seen, 1'b1);
        end
        xfer({`FXR_OP_DIODTR, 8'h00}, 8);
        check(rej_seen, 1'b1);
        xfer({`FXR_OP_RD_EXT, 8'h00}, 16);
        check(rx, 8'hF0);
        qpi_mode_i <= 1'b0;
        @(posedge clk_sys_i);
        $display("test dummy counts done");
        for (i = 0; i < 10; i = i + 1) begin
            code = (i < 2) ? {i[0], 2'b00} : 3'($random(seed));
            xfer({`FXR_OP_SET_V, code, 5'($random(seed))}, 16);
            if (code != 3'h0 && code != 3'h4)
                ods = code;
            check(ds_o, ods);
            check(ext_status_o, {ods, 5'h10});
        end
        $display("test strength codes done");
        op_run(`FXR_K_PAGE_PROG, 13'h1031, 3'h2);
        xfer({`FXR_OP_SET_V, 8'hA0}, 16);
        xfer({`FXR_OP_RD_EXT, 8'h00}, 16);
        check(rx, 8'hB4);
        nv_seen = 1'b0;
        xfer({`FXR_OP_SET_NV, 8'h5F}, 16);
        check(nv_seen, 1'b1);
        op_run(`FXR_K_NV_REG, 13'h0031, 3'h2);
        check({nv_ds_o, ds_o}, 6'h15);
        xfer({`FXR_OP_RD_EXT, 8'h00}, 16);
        check(rx, 8'hB4);
        $display("test flag preservation done");
        op_chk(`FXR_K_PAGE_PROG, 13'h1031, 3'h2);
        op_chk(`FXR_K_PAGE_PROG, 13'h0431, 3'h3);
        op_chk(`FXR_K_PAGE_PROG, 13'h0231, 3'h3);
        op_chk(`FXR_K_PPB_PROG, 13'h1031, 3'h2);
        op_chk(`FXR_K_PWD_PROG, 13'h1031, 3'h2);
        op_chk(`FXR_K_IR_PROG, 13'h0131, 3'h3);
        op_chk(`FXR_K_FUNC_WR, 13'h1031, 3'h2);
        op_chk(`FXR_K_FUNC_WR, 13'h0031, 3'h0);
        op_chk(`FXR_K_PROT_CFG, 13'h0071, 3'h3);
        op_chk(`FXR_K_PROT_CFG, 13'h0001, 3'h3);
        op_chk(`FXR_K_PROT_CFG, 13'h1039, 3'h0);
        op_chk(`FXR_K_PWD_UNLOCK, 13'h0035, 3'h3);
        op_chk(`FXR_K_NV_REG, 13'h0831, 3'h4);
        op_chk(`FXR_K_NV_REG, 13'h1031, 3'h2);
        op_chk(`FXR_K_STATUS_WR, 13'h0032, 3'h5);
        op_chk(`FXR_K_STATUS_WR, 13'h0033, 3'h0);
        op_chk(`FXR_K_SECT_ERASE, 13'h0831, 3'h4);
        op_chk(`FXR_K_SECT_ERASE, 13'h0431, 3'h5);
        op_chk(`FXR_K_IR_ERASE, 13'h0131, 3'h5);
        op_chk(`FXR_K_PPB_ERASE, 13'h0831, 3'h4);
        op_chk(`FXR_K_CHIP_ERASE, 13'h00B1, 3'h5);
        op_chk(`FXR_K_CHIP_ERASE, 13'h0431, 3'h0);
        $display("test error flags done");
        test_done;
    end
endmodule
